// ### hw/sms_sequencer.sv
// Measurement sequencer: conversion timing, pulse timing, sync start and protection gates.

module sms_sequencer (
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    input wire sms_pkg::sms_cfg_type CFG_IN,
    input wire logic SYNC_IN_PIN_IN,
    input wire logic RETURN_CMP_IN,
    input wire logic ADC_DONE_IN,
    input wire logic [9:0] ADC_CODE_IN,
    output logic ADC_START_OUT,
    output sms_pkg::sms_src_type MUX_SEL_OUT,
    output sms_pkg::sms_gain_type GAIN_SEL_OUT,
    output logic IMP_SWITCH_OUT,
    output logic REF_SWITCH_OUT,
    output logic BANDGAP_SWITCH_OUT,
    output logic MEAS_ACTIVE_OUT,
    output logic PROT_GATE_A_OUT,
    output logic PROT_GATE_B_OUT,
    output logic RETURN_SHORT_BATT_OUT,
    output sms_pkg::sms_result_type RESULT_OUT
);

    typedef enum logic [2:0] {S_IDLE, S_IMP1, S_IMP_PULSE, S_IMP2, S_REF, S_FILT, S_REF_PULSE,
        S_BG_PULSE} sms_state_type;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic sync_s1_r, sync_s2_r, sync_s3_r;
    logic cmp_s1_r, cmp_s2_r;
    logic sync_rise;

    // Both pins are asynchronous; the first stage feeds only the second.
    always_ff @(posedge MCLK_IN)
    begin
        if (RESET_IN)
        begin
            sync_s1_r <= 1'b0;
            sync_s2_r <= 1'b0;
            sync_s3_r <= 1'b0;
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
        end
        else
        begin
            sync_s1_r <= SYNC_IN_PIN_IN;
            sync_s2_r <= sync_s1_r;
            sync_s3_r <= sync_s2_r;
            cmp_s1_r <= RETURN_CMP_IN;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    // Rising edge of the sync pin, seen one cycle after it settles.
    assign sync_rise = sync_s2_r & ~sync_s3_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Protection gates and return-pin short detection.

    logic gate_a_r, gate_b_r, short_r;
    logic gate_a_nxt, gate_b_nxt, short_nxt;

    // The comparator is only meaningful while a gate grounds the return pin.
    always_comb
    begin
        gate_a_nxt = CFG_IN.prot_gate_a_enable;
        gate_b_nxt = CFG_IN.prot_gate_b_enable;
        short_nxt = (gate_a_r | gate_b_r) & cmp_s2_r;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (RESET_IN)
        begin
            gate_a_r <= 1'b0;
            gate_b_r <= 1'b0;
            short_r <= 1'b0;
        end
        else
        begin
            gate_a_r <= gate_a_nxt;
            gate_b_r <= gate_b_nxt;
            short_r <= short_nxt;
        end
    end

    assign PROT_GATE_A_OUT = gate_a_r;
    assign PROT_GATE_B_OUT = gate_b_r;
    assign RETURN_SHORT_BATT_OUT = short_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer tick generator.

    sms_pkg::sms_timing_type tcfg_r;
    logic [11:0] tick_cnt_r, tick_cnt_nxt;
    logic tick;

    // Last count of one tick for a period select; the period doubles per step.
    function automatic logic [11:0] tick_last(input logic [1:0] sel);
        tick_last = (sms_pkg::SEQ_TICK_BASE << sel) - 12'h001;
    endfunction

    // The period comes from the snapshot, so it cannot change inside a cycle.
    always_comb
    begin
        tick = (tick_cnt_r >= tick_last(tcfg_r.meas_clock_period_sel));
        tick_cnt_nxt = tick ? sms_pkg::TICK_CNT_RESET : tick_cnt_r + 12'h001;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (RESET_IN)
        begin
            tick_cnt_r <= sms_pkg::TICK_CNT_RESET;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Measurement state machine.

    sms_state_type state_r, state_nxt;
    sms_pkg::sms_timing_type tcfg_nxt;
    sms_pkg::sms_result_type res_r, res_nxt;
    sms_pkg::sms_src_type mux_r, mux_nxt;
    sms_pkg::sms_gain_type gain_r, gain_nxt;
    logic [6:0] pcnt_r, pcnt_nxt, width;
    logic busy_r, busy_nxt, start_r, start_nxt, cycle_end;

    // Pulse length in ticks for the pulse states.
    function automatic logic [6:0] pulse_width(input sms_state_type st,
                                               input sms_pkg::sms_timing_type t);
        if (st == S_IMP_PULSE)
            pulse_width = t.impedance_pulse_time;
        else if (st == S_REF_PULSE)
            pulse_width = {4'h0, t.ref_switch_pulse_time};
        else
            pulse_width = t.bandgap_pulse_time;
    endfunction

    // Next state, conversions, pulse timing and result capture.
    always_comb
    begin
        state_nxt = state_r;
        tcfg_nxt = tcfg_r;
        res_nxt = res_r;
        pcnt_nxt = pcnt_r;
        busy_nxt = busy_r;
        start_nxt = 1'b0;
        cycle_end = 1'b0;
        width = pulse_width(state_r, tcfg_r);
        case (state_r)
            S_IDLE:
            begin
                // A sync edge is only looked at here, so edges in a cycle are lost.
                if (!CFG_IN.sync_mode_sel || sync_rise)
                begin
                    tcfg_nxt = CFG_IN.timing;
                    state_nxt = S_IMP1;
                end
            end
            S_IMP1, S_IMP2, S_REF, S_FILT:
            begin
                if (!busy_r)
                begin
                    start_nxt = 1'b1;
                    busy_nxt = 1'b1;
                end
                else if (ADC_DONE_IN)
                begin
                    busy_nxt = 1'b0;
                    case (state_r)
                        S_IMP1:
                        begin
                            res_nxt.imp_code_a = ADC_CODE_IN;
                            state_nxt = S_IMP_PULSE;
                        end
                        S_IMP2:
                        begin
                            res_nxt.imp_code_b = ADC_CODE_IN;
                            state_nxt = S_REF;
                        end
                        S_REF:
                        begin
                            res_nxt.ref_cell_code = ADC_CODE_IN;
                            state_nxt = S_FILT;
                        end
                        default:
                        begin
                            res_nxt.filt_code = ADC_CODE_IN + sms_pkg::FV_MIDSCALE;
                            state_nxt = S_REF_PULSE;
                        end
                    endcase
                end
            end
            default:
            begin
                // A zero width still lasts one tick so the switch is seen.
                if (tick)
                begin
                    if ({1'b0, pcnt_r} + 8'h01 >= {1'b0, width})
                    begin
                        pcnt_nxt = sms_pkg::PULSE_CNT_RESET;
                        if (state_r == S_IMP_PULSE)
                            state_nxt = S_IMP2;
                        else if (state_r == S_REF_PULSE)
                            state_nxt = S_BG_PULSE;
                        else
                        begin
                            state_nxt = S_IDLE;
                            cycle_end = 1'b1;
                        end
                    end
                    else
                    begin
                        pcnt_nxt = pcnt_r + 7'h01;
                    end
                end
            end
        endcase
        // The 3-bit field wraps from seven to zero by itself.
        if (cycle_end)
            res_nxt.cycle_count = res_r.cycle_count + 3'h1;
        if (state_nxt == S_IMP1 || state_nxt == S_IMP2)
            mux_nxt = sms_pkg::SRC_IMPEDANCE;
        else if (state_nxt == S_REF)
            mux_nxt = sms_pkg::SRC_REF_CELL;
        else if (state_nxt == S_FILT)
            mux_nxt = sms_pkg::SRC_FILTERED;
        else
            mux_nxt = sms_pkg::SRC_NONE;
        // Programmed gain only on the control voltage; amplifier inputs stay at unity.
        gain_nxt = (mux_nxt == sms_pkg::SRC_FILTERED) ? CFG_IN.scale_gain_sel
                                                      : sms_pkg::GAIN_X1;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (RESET_IN)
        begin
            state_r <= S_IDLE;
            tcfg_r <= '0;
            res_r <= '0;
            pcnt_r <= sms_pkg::PULSE_CNT_RESET;
            busy_r <= 1'b0;
            start_r <= 1'b0;
            mux_r <= sms_pkg::SRC_NONE;
            gain_r <= sms_pkg::GAIN_X1;
        end
        else
        begin
            state_r <= state_nxt;
            tcfg_r <= tcfg_nxt;
            res_r <= res_nxt;
            pcnt_r <= pcnt_nxt;
            busy_r <= busy_nxt;
            start_r <= start_nxt;
            mux_r <= mux_nxt;
            gain_r <= gain_nxt;
        end
    end

    // Outputs straight from the state registers.
    assign ADC_START_OUT = start_r;
    assign MUX_SEL_OUT = mux_r;
    assign GAIN_SEL_OUT = gain_r;
    assign IMP_SWITCH_OUT = (state_r == S_IMP_PULSE);
    assign REF_SWITCH_OUT = (state_r == S_REF_PULSE);
    assign BANDGAP_SWITCH_OUT = (state_r == S_BG_PULSE);
    assign MEAS_ACTIVE_OUT = (state_r != S_IDLE);
    assign RESULT_OUT = res_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RESET_IN);

    gate_follow_a: assert property ($changed(CFG_IN.prot_gate_a_enable)
        |=> PROT_GATE_A_OUT == $past(CFG_IN.prot_gate_a_enable))
        else $error("Gate A does not follow its enable.");
    gate_follow_b_a: assert property ($changed(CFG_IN.prot_gate_b_enable)
        |=> PROT_GATE_B_OUT == $past(CFG_IN.prot_gate_b_enable))
        else $error("Gate B does not follow its enable.");
    short_detect_a: assert property (cmp_s2_r
        && (PROT_GATE_A_OUT || PROT_GATE_B_OUT) |=> RETURN_SHORT_BATT_OUT)
        else $error("Return short not flagged.");
    short_gated_a: assert property (!PROT_GATE_A_OUT && !PROT_GATE_B_OUT
        |=> !RETURN_SHORT_BATT_OUT)
        else $error("Return short flagged with gates off.");
    gain_forced_a: assert property (MUX_SEL_OUT != sms_pkg::SRC_FILTERED
        |-> GAIN_SEL_OUT == sms_pkg::GAIN_X1)
        else $error("Gain not unity for amplifier source.");
    fv_offset_a: assert property (state_r == S_FILT && busy_r && ADC_DONE_IN
        |=> RESULT_OUT.filt_code == $past(ADC_CODE_IN) + 10'h200)
        else $error("Control voltage code not offset to midscale.");
    timing_frozen_a: assert property (MEAS_ACTIVE_OUT ##1 MEAS_ACTIVE_OUT
        |-> $stable(tcfg_r))
        else $error("Timing changed inside a cycle.");
    cycle_step_a: assert property (cycle_end
        |=> RESULT_OUT.cycle_count == $past(RESULT_OUT.cycle_count) + 3'h1)
        else $error("Cycle counter did not step.");
    sync_wait_a: assert property (!MEAS_ACTIVE_OUT && CFG_IN.sync_mode_sel
        && !sync_rise |=> !MEAS_ACTIVE_OUT)
        else $error("Cycle started without a sync edge.");
    imp_twice_a: assert property (state_r == S_IMP_PULSE && state_nxt == S_IMP2
        |=> MUX_SEL_OUT == sms_pkg::SRC_IMPEDANCE ##1 ADC_START_OUT)
        else $error("Second impedance conversion missing.");
    hold_result_a: assert property (state_r != S_REF
        |=> $stable(RESULT_OUT.ref_cell_code))
        else $error("Reference cell result changed outside its slot.");
    full_cycle_c: cover property (cycle_end);
    sync_start_c: cover property (CFG_IN.sync_mode_sel && sync_rise && !MEAS_ACTIVE_OUT);
    sync_drop_c: cover property (CFG_IN.sync_mode_sel && sync_rise && MEAS_ACTIVE_OUT);
    count_wrap_c: cover property (cycle_end && RESULT_OUT.cycle_count == 3'h7);

endmodule

// ### hw/sms_pkg.sv
// Shared constants and carrier types for the sensor measurement sequencer.
package sms_pkg;

    // Converter result width and the offset that centres the control voltage code.
    localparam int ADC_W = 10;
    localparam logic [9:0] FV_MIDSCALE = 10'h200;

    // Sequencer tick length in core clocks for period select 0; doubled per step.
    localparam logic [11:0] SEQ_TICK_BASE = 12'h010;

    // Values after reset.
    localparam logic [2:0] CYCLE_CNT_RESET = 3'h0;
    localparam logic [9:0] CODE_RESET = 10'h000;
    localparam logic [6:0] PULSE_CNT_RESET = 7'h00;
    localparam logic [11:0] TICK_CNT_RESET = 12'h000;

    // Scaling gain codes: 1, 1.5, 2, 3, 4, 6, 8 and 12 in this order.
    typedef enum logic [2:0] {
        GAIN_X1, GAIN_X1P5, GAIN_X2, GAIN_X3, GAIN_X4, GAIN_X6, GAIN_X8, GAIN_X12
    } sms_gain_type;

    // Converter input multiplexer selection.
    typedef enum logic [1:0] {
        SRC_NONE, SRC_REF_CELL, SRC_IMPEDANCE, SRC_FILTERED
    } sms_src_type;

    // Timing settings, taken over only at the start of a measurement cycle.
    typedef struct packed {
        logic [1:0] meas_clock_period_sel;
        logic [6:0] impedance_pulse_time;
        logic [6:0] bandgap_pulse_time;
        logic [2:0] ref_switch_pulse_time;
    } sms_timing_type;

    // Host configuration as written over the serial port.
    typedef struct packed {
        sms_gain_type scale_gain_sel;
        sms_timing_type timing;
        logic sync_mode_sel;
        logic prot_gate_a_enable;
        logic prot_gate_b_enable;
    } sms_cfg_type;

    // Results presented to the serial output frame.
    typedef struct packed {
        logic [9:0] ref_cell_code;
        logic [9:0] filt_code;
        logic [9:0] imp_code_a;
        logic [9:0] imp_code_b;
        logic [2:0] cycle_count;
    } sms_result_type;

endpackage

// ### tb/sms_adc_model.sv
// Behavioural converter that answers each start pulse with a done pulse and a code.
module sms_adc_model (
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    input wire logic START_IN,
    input wire logic SLOW_IN,
    output logic DONE_OUT,
    output logic [9:0] CODE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;

    logic busy = 1'b0;
    int wait_cnt = 0;
    logic [9:0] last_code = 10'h000;
    logic [9:0] new_code;

    ////////////////////////////////////////////////////////////////////////////////
    // Driven from time zero so the sequencer never sees an unknown done or code.
    initial
    begin
        DONE_OUT = 1'b0;
        CODE_OUT = 10'h3FF;
    end

    // A conversion takes one clock when prompt or a random time when slow.
    // Outside the done cycle the code is inverted so a stale value never matches.
    always @(posedge MCLK_IN)
    begin
        DONE_OUT <= 1'b0;
        CODE_OUT <= ~last_code;
        if (RESET_IN)
            busy <= 1'b0;
        else if (START_IN)
        begin
            busy <= 1'b1;
            wait_cnt <= SLOW_IN ? $urandom_range(40, 1) : 0;
        end
        else if (busy && wait_cnt > 0)
            wait_cnt <= wait_cnt - 1;
        else if (busy)
        begin
            new_code = 10'($urandom);
            busy <= 1'b0;
            DONE_OUT <= 1'b1;
            CODE_OUT <= new_code;
            last_code <= new_code;
        end
    end
endmodule

// ### tb/test_sensor_measurement_sequencer.sv
// Self-checking bench for the sensor measurement sequencer.
module test_sensor_measurement_sequencer;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    sms_pkg::sms_cfg_type cfg = '0;
    logic sync_pin = 1'b0;
    logic ret_cmp = 1'b0;
    logic slow = 1'b0;
    logic adc_done, adc_start, imp_sw, ref_sw, bg_sw, meas_act, pg_a, pg_b, short_flag;
    logic [9:0] adc_code;
    sms_pkg::sms_src_type mux;
    sms_pkg::sms_gain_type gain;
    sms_pkg::sms_result_type res;
    sms_pkg::sms_result_type exp_res = '0;
    sms_pkg::sms_cfg_type cfg_q = '0;
    sms_pkg::sms_cfg_type cfg_run = '0;
    int error_cnt = 0;
    int checks = 0;
    int starts = 0;
    int rf_w = 0;
    int imp_n = 0;
    int conv_n = 0;
    int imp_w = 0;
    int bg_w = 0;
    int s = 0;
    logic done_d = 1'b0;
    logic ma_d = 1'b0;
    logic [9:0] code_d = 10'h000;
    sms_pkg::sms_src_type mux_d = sms_pkg::SRC_NONE;
    logic [2:0] gain_exp = 3'h0;

    sms_sequencer i_dut (.MCLK_IN(mclk), .RESET_IN(rst), .CFG_IN(cfg), .SYNC_IN_PIN_IN(sync_pin),
        .RETURN_CMP_IN(ret_cmp), .ADC_DONE_IN(adc_done), .ADC_CODE_IN(adc_code),
        .ADC_START_OUT(adc_start), .MUX_SEL_OUT(mux), .GAIN_SEL_OUT(gain), .IMP_SWITCH_OUT(imp_sw),
        .REF_SWITCH_OUT(ref_sw), .BANDGAP_SWITCH_OUT(bg_sw), .MEAS_ACTIVE_OUT(meas_act),
        .PROT_GATE_A_OUT(pg_a), .PROT_GATE_B_OUT(pg_b), .RETURN_SHORT_BATT_OUT(short_flag),
        .RESULT_OUT(res));

    sms_adc_model i_adc (.MCLK_IN(mclk), .RESET_IN(rst), .START_IN(adc_start), .SLOW_IN(slow),
        .DONE_OUT(adc_done), .CODE_OUT(adc_code));

    ////////////////////////////////////////////////////////////////////////////////
    // Compares a seen value with the expected one and counts both outcomes.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Waits, with a bound, until the cycle-active flag shows the wanted level.
    task automatic wait_ma(input logic v);
        int t = 0;
        @(posedge mclk);
        #1;
        while (meas_act !== v && t < 5000)
        begin
            @(posedge mclk);
            #1;
            t++;
        end
        if (t == 5000)
            check(meas_act, v);
    endtask

    // A pulse may start mid-tick, so its first tick can be short by up to one tick.
    function automatic bit in_rng(int w, int t, logic [1:0] sel);
        int tk;
        int n;
        tk = int'(sms_pkg::SEQ_TICK_BASE) << sel;
        n = (t == 0) ? 1 : t;
        return (w >= (n - 1) * tk + 1) && (w <= n * tk);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Core clock at 250 MHz.
    initial
    begin
        forever #2 mclk = ~mclk;
    end

    // Bounds the run far above the longest expected sequence; a hang counts as a mismatch.
    initial
    begin
        repeat (80000) @(posedge mclk);
        error_cnt++;
        summarize();
    end

    // Reference model: old values are read at each edge, so cfg_q holds the settings
    // that the design sampled one edge earlier.
    always @(posedge mclk)
    begin
        if (rst)
            exp_res = '0;
        else
        begin
            if (ma_d && !meas_act)
            begin
                exp_res.cycle_count = exp_res.cycle_count + 3'h1;
                check(imp_n, 2);
                check(conv_n, 4);
            end
            if (meas_act && !ma_d)
            begin
                cfg_run = cfg_q;
                imp_n = 0;
                conv_n = 0;
                starts++;
            end
            if (done_d)
            begin
                conv_n++;
                if (mux_d == sms_pkg::SRC_REF_CELL)
                    exp_res.ref_cell_code = code_d;
                else if (mux_d == sms_pkg::SRC_FILTERED)
                    exp_res.filt_code = code_d + sms_pkg::FV_MIDSCALE;
                else if (imp_n++ == 0)
                    exp_res.imp_code_a = code_d;
                else
                    exp_res.imp_code_b = code_d;
            end
            check(res, exp_res);
            if (mux == sms_pkg::SRC_FILTERED && mux_d != sms_pkg::SRC_FILTERED)
                gain_exp = cfg_q.scale_gain_sel;
            check(gain, (mux == sms_pkg::SRC_FILTERED) ? gain_exp : 3'h0);
            if (imp_sw)
                imp_w++;
            else if (imp_w > 0)
            begin
                check(in_rng(imp_w, cfg_run.timing.impedance_pulse_time,
                    cfg_run.timing.meas_clock_period_sel), 1);
                imp_w = 0;
            end
            if (bg_sw)
                bg_w++;
            else if (bg_w > 0)
            begin
                check(in_rng(bg_w, cfg_run.timing.bandgap_pulse_time,
                    cfg_run.timing.meas_clock_period_sel), 1);
                bg_w = 0;
            end
            if (ref_sw)
                rf_w++;
            else if (rf_w > 0)
            begin
                check(in_rng(rf_w, cfg_run.timing.ref_switch_pulse_time,
                    cfg_run.timing.meas_clock_period_sel), 1);
                rf_w = 0;
            end
            // A conversion may only be started with a source routed to the converter.
            if (adc_start)
                check(mux != sms_pkg::SRC_NONE, 1);
        end
        done_d = adc_done;
        code_d = adc_code;
        mux_d = mux;
        ma_d = meas_act;
        cfg_q = cfg;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: gates and short flag, free-running cycles, then sync starts.
    initial
    begin
        void'($urandom(31382));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge mclk);
            cfg.prot_gate_a_enable <= i[0];
            cfg.prot_gate_b_enable <= i[1];
            ret_cmp <= i[2];
            @(posedge mclk);
            #1;
            check({pg_a, pg_b}, {i[0], i[1]});
            repeat (2) @(posedge mclk);
            #1;
            check(short_flag, i[2] & (i[0] | i[1]));
        end
        // Settings change mid-cycle; gain steps through all eight codes.
        for (int n = 0; n < 10; n++)
        begin
            wait_ma(1'b1);
            repeat (3) @(posedge mclk);
            // Only sequencer fields and the converter speed move mid-cycle; gate enables and sync mode are never touched.
            cfg.scale_gain_sel <= sms_pkg::sms_gain_type'(n[2:0]);
            cfg.timing.meas_clock_period_sel <= 2'(n);
            cfg.timing.impedance_pulse_time <= 7'($urandom_range(4));
            cfg.timing.bandgap_pulse_time <= 7'($urandom_range(4));
            cfg.timing.ref_switch_pulse_time <= 3'($urandom_range(7));
            slow <= n[0];
            wait_ma(1'b0);
        end
        // Synchronized mode: long pulse keeps extra sync edges inside the cycle.
        wait_ma(1'b1);
        @(posedge mclk);
        cfg.sync_mode_sel <= 1'b1;
        cfg.timing.impedance_pulse_time <= 7'h04;
        wait_ma(1'b0);
        repeat (40) @(posedge mclk);
        #1;
        check(meas_act, 0);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge mclk);
            sync_pin <= 1'b1;
            s = starts;
            // Two sync flops; the edge is seen in the third cycle and starts the cycle there.
            repeat (2) @(posedge mclk);
            #1;
            check(meas_act, 0);
            @(posedge mclk);
            #1;
            check(meas_act, 1);
            repeat (13)
            begin
                repeat (4) @(posedge mclk);
                sync_pin <= ~sync_pin;
            end
            wait_ma(1'b0);
            repeat (30) @(posedge mclk);
            #1;
            check(starts - s, 1);
        end
        summarize();
    end
endmodule
